// [pkg/ersc_pkg.sv]
`default_nettype none
package ersc_pkg;

   // ---------------------------------------------------------------
   // Register map and widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [7:0] OFF_EE_CTRL  = 8'h00;
   localparam logic [7:0] OFF_RX_CFG   = 8'h04;
   localparam logic [7:0] OFF_TX_CFG   = 8'h08;
   localparam logic [7:0] OFF_LINK_CFG = 8'h0C;
   localparam logic [7:0] OFF_STATUS   = 8'h10;
   localparam logic [7:0] OFF_SRESET   = 8'h14;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int EE_DATA_BIT    = 0;
   localparam int EE_SK_BIT      = 1;
   localparam int EE_CS_BIT      = 2;
   localparam int EE_PRESENT_BIT = 3;
   localparam int CFG_POL_BIT    = 0;
   localparam int CFG_SRC_LSB    = 1;

   // Network status inputs, selectable by each indicator.
   localparam int NS_RX_ACT  = 0;
   localparam int NS_TX_ACT  = 1;
   localparam int NS_LINK_OK = 2;
   localparam int NS_COLL    = 3;

   // ---------------------------------------------------------------
   // Reset values and NAND tree width
   // ---------------------------------------------------------------
   localparam logic [2:0] RX_CFG_RST   = 3'h0;
   localparam logic [2:0] TX_CFG_RST   = 3'h2;
   localparam logic [2:0] LINK_CFG_RST = 3'h4;
   localparam logic [2:0] EE_CTRL_RST  = 3'h0;
   localparam int NAND_W = 50;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_REQ   = 4'h2,
      ST_DRAIN = 4'h4,
      ST_SLEEP = 4'h8
   } ersc_state_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ersc_reg_req_t;

   typedef struct packed {
      logic [1:0] src;
      logic       pol;
   } ersc_ind_cfg_t;

endpackage : ersc_pkg
`default_nettype wire

// [logic/ersc_ctrl.sv]
// Behaviour
// RQ1: Bus request, once raised, stays until grant despite sleep, stop or soft reset.
// RQ2: Reset low puts block in hard reset with all outputs disabled.
// RQ3: System holds reset low for at least 30 host clocks.
// RQ4: Reset accepted asynchronously; release is synchronised before use.
// RQ5: During reset all bus pins are inputs; NAND tree drives activity output.
// RQ6: At reset release the serial clock pin sets the EEPROM-present flag.
// RQ7: Receive indicator defaults active low on receive activity; programmable.
// RQ8: Transmit indicator defaults active low on transmit activity; programmable.
// RQ9: Link indicator defaults active low on link up; programmable.
// RQ10: Sleep low triggers soft reset sparing config, then power saving.
// RQ11: Host bus interface and configuration stay intact during sleep.
// RQ12: Every register access while sleeping answers with target abort.
// RQ13: Sleeping: no bus request, outputs in soft-reset state, inputs ignored.
// RQ14: Sleep during pending request waits for grant, drops request, sleeps.
// RQ15: System waits half a second after wake before network use.
// RQ16: System supplies host and crystal clocks for sleep to act.
// RQ17: System asserts sleep no sooner than three clocks after reset.
// RQ18: Sleep has no effect on the storage-bus section.
// RQ19: Network bit rate is half the crystal frequency.
// RQ20: External crystal source keeps toggling 30 cycles after sleep entry.
// RQ21: Auto EEPROM read drives serial clock; otherwise host bit 1 does.
// RQ22: Present flag held until next hard reset; reset release synchronised.
`timescale 1ns/1ps
`default_nettype none
module ersc_ctrl #(
   parameter int NAND_W = ersc_pkg::NAND_W
) (
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   // Register port
   input  wire ersc_pkg::ersc_reg_req_t reg_req,
   output logic [ersc_pkg::DATA_W-1:0] reg_rdata,
   output logic                        io_target_abort,
   // Host bus arbitration
   input  wire logic                   want_bus,
   input  wire logic                   eth_bus_grant_n,
   input  wire logic                   eth_bus_request_n_i,
   output logic                        eth_bus_request_n_o,
   output logic                        eth_bus_request_oe,
   // Sleep and power
   input  wire logic                   sleep_n,
   output logic                        power_save,
   output logic                        soft_reset,
   // NAND tree and activity monitor
   input  wire logic [NAND_W-1:0]      nand_pins_i,
   input  wire logic                   scsi_busy_n,
   output logic                        bus_activity_n,
   // Network status and crystal
   input  wire logic [3:0]             net_status,
   input  wire logic                   crystal_input,
   output logic                        bit_rate_tick,
   // EEPROM read engine
   input  wire logic                   auto_read_busy,
   input  wire logic                   auto_sk,
   input  wire logic                   auto_cs,
   input  wire logic                   auto_di,
   output logic                        eeprom_chip_select,
   output logic                        eeprom_present_flag,
   // Shared pins
   input  wire logic                   eeprom_serial_clock_i,
   output logic                        eeprom_serial_clock_o,
   output logic                        eeprom_serial_clock_oe,
   input  wire logic                   eeprom_data_out_line_i,
   output logic                        eeprom_data_out_line_o,
   output logic                        eeprom_data_out_line_oe,
   output logic                        eeprom_data_in_line_o,
   output logic                        eeprom_data_in_line_oe
);

   // ---------------------------------------------------------------
   // Reset synchronisation
   // ---------------------------------------------------------------
   logic rst_s1_r;
   logic rst_s2_r;
   logic hrst_d_r;
   wire  hreset     = ~rst_s2_r;
   wire  hold       = ~rst_n | hreset;
   wire  release_ev = hrst_d_r & ~hreset;

   // A raw release could land mid-edge; the core only sees it two
   // clocks later, so its state leaves reset cleanly.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0; // RQ4
      end else begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r; // RQ22
      end
      hrst_d_r <= hold;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   ersc_pkg::ersc_state_t state_r;
   ersc_pkg::ersc_state_t state_nxt;
   ersc_pkg::ersc_ind_cfg_t rx_cfg_r;
   ersc_pkg::ersc_ind_cfg_t tx_cfg_r;
   ersc_pkg::ersc_ind_cfg_t link_cfg_r;
   logic [2:0] ee_ctrl_r;
   logic       present_r;
   logic [ersc_pkg::DATA_W-1:0] rdata_r;
   logic [ersc_pkg::DATA_W-1:0] rdata_nxt;
   logic       sreset_r;
   logic       busy_r;
   logic       sk_r;
   logic       di_r;
   logic       do_r;
   logic       cs_r;
   logic       xtal_q_r;
   logic       half_r;
   logic       tick_r;

   wire sleep_req = ~sleep_n;
   wire sleeping  = (state_r == ersc_pkg::ST_SLEEP);
   wire grant     = ~eth_bus_grant_n;
   wire requesting = (state_r == ersc_pkg::ST_REQ) |
                     (state_r == ersc_pkg::ST_DRAIN);
   wire acc       = reg_req.wr | reg_req.rd;
   wire wr_ok     = reg_req.wr & ~sleeping; // RQ12
   wire rd_ok     = reg_req.rd & ~sleeping;
   wire sel_ee    = reg_req.addr == ersc_pkg::OFF_EE_CTRL;
   wire sel_rx    = reg_req.addr == ersc_pkg::OFF_RX_CFG;
   wire sel_tx    = reg_req.addr == ersc_pkg::OFF_TX_CFG;
   wire sel_link  = reg_req.addr == ersc_pkg::OFF_LINK_CFG;
   wire sel_stat  = reg_req.addr == ersc_pkg::OFF_STATUS;
   wire sel_srst  = reg_req.addr == ersc_pkg::OFF_SRESET;
   wire srst_port = (wr_ok | rd_ok) & sel_srst;
   wire enter_sleep = (state_nxt == ersc_pkg::ST_SLEEP) & ~sleeping;

   // Network status and EEPROM inputs are ignored while asleep.
   wire [3:0] ns   = sleeping ? 4'h0 : net_status; // RQ13
   wire auto_rd    = auto_read_busy & ~sleeping;
   wire ee_access  = (auto_rd | ee_ctrl_r[ersc_pkg::EE_CS_BIT]) &
                     ~sleeping; // RQ13

   // ---------------------------------------------------------------
   // Bus request and sleep sequencing
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ersc_pkg::ST_IDLE: begin
            if (sleep_req) begin
               state_nxt = ersc_pkg::ST_SLEEP; // RQ10
            end else if (want_bus) begin
               state_nxt = ersc_pkg::ST_REQ;
            end
         end
         ersc_pkg::ST_REQ: begin
            // Stop and soft-reset accesses do not touch this state.
            if (grant) begin
               state_nxt = sleep_req ? ersc_pkg::ST_SLEEP
                                     : ersc_pkg::ST_IDLE; // RQ1
            end else if (sleep_req) begin
               state_nxt = ersc_pkg::ST_DRAIN; // RQ14
            end
         end
         ersc_pkg::ST_DRAIN: begin
            if (grant) begin
               state_nxt = ersc_pkg::ST_SLEEP; // RQ14
            end
         end
         ersc_pkg::ST_SLEEP: begin
            if (!sleep_req) begin
               state_nxt = ersc_pkg::ST_IDLE;
            end
         end
         default: state_nxt = ersc_pkg::ST_IDLE;
      endcase
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   wire [ersc_pkg::DATA_W-1:0] ee_word = {12'h000, present_r,
      ee_ctrl_r[2:1], eeprom_data_out_line_i};
   wire [ersc_pkg::DATA_W-1:0] stat_word = {11'h000, sleeping,
      state_r};
   assign rdata_nxt = !rd_ok  ? 16'h0000 :
                      sel_ee   ? ee_word :
                      sel_rx   ? {13'h0000, rx_cfg_r} :
                      sel_tx   ? {13'h0000, tx_cfg_r} :
                      sel_link ? {13'h0000, link_cfg_r} :
                      sel_stat ? stat_word : 16'h0000;

   // ---------------------------------------------------------------
   // Indicators and shared pins
   // ---------------------------------------------------------------
   function automatic logic ind_pin(input ersc_pkg::ersc_ind_cfg_t c,
                                    input logic [3:0] s,
                                    input logic off);
      logic act;
      act = off ? 1'b0 : s[c.src];
      ind_pin = c.pol ? act : ~act;
   endfunction : ind_pin

   function automatic logic nand_chain(input logic [NAND_W-1:0] p);
      logic r;
      r = p[0];
      for (int i = 1; i < NAND_W; i++) begin
         r = ~(r & p[i]);
      end
      nand_chain = r;
   endfunction : nand_chain

   wire rx_led   = ind_pin(rx_cfg_r, ns, sleeping); // RQ7
   wire tx_led   = ind_pin(tx_cfg_r, ns, sleeping); // RQ8
   wire link_led = ind_pin(link_cfg_r, ns, sleeping); // RQ9
   wire sk_src   = auto_rd ? auto_sk
                           : ee_ctrl_r[ersc_pkg::EE_SK_BIT]; // RQ21
   wire di_src   = auto_rd ? auto_di : ee_ctrl_r[ersc_pkg::EE_DATA_BIT];
   wire sk_nxt   = ee_access ? sk_src : rx_led;
   wire di_nxt   = ee_access ? di_src : link_led;
   wire cs_nxt   = ee_access &
                   (auto_rd ? auto_cs : ee_ctrl_r[ersc_pkg::EE_CS_BIT]);
   wire xtal_rise = crystal_input & ~xtal_q_r;

   always_ff @(posedge mclk) begin
      if (hold) begin
         state_r <= ersc_pkg::ST_IDLE;
         ee_ctrl_r <= ersc_pkg::EE_CTRL_RST;
         rx_cfg_r <= ersc_pkg::RX_CFG_RST;
         tx_cfg_r <= ersc_pkg::TX_CFG_RST;
         link_cfg_r <= ersc_pkg::LINK_CFG_RST;
         rdata_r <= 16'h0000;
         sreset_r <= 1'b0;
         sk_r <= 1'b0;
         di_r <= 1'b0;
         do_r <= 1'b1;
         cs_r <= 1'b0;
         half_r <= 1'b0;
         tick_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         rdata_r <= rdata_nxt;
         sreset_r <= enter_sleep | srst_port; // RQ10
         // Sleep keeps every configuration word; only the pins go quiet.
         if (wr_ok && sel_ee) begin
            ee_ctrl_r <= reg_req.wdata[2:0]; // RQ11
         end
         if (wr_ok && sel_rx) begin
            rx_cfg_r <= reg_req.wdata[2:0];
         end
         if (wr_ok && sel_tx) begin
            tx_cfg_r <= reg_req.wdata[2:0];
         end
         if (wr_ok && sel_link) begin
            link_cfg_r <= reg_req.wdata[2:0];
         end
         sk_r <= sk_nxt;
         di_r <= di_nxt;
         do_r <= tx_led;
         cs_r <= cs_nxt;
         if (xtal_rise) begin
            half_r <= ~half_r;
         end
         tick_r <= xtal_rise & half_r; // RQ19
      end
      xtal_q_r <= crystal_input;
      // The request pin is the last input of the tree.
      busy_r <= hold ? ~(nand_chain(nand_pins_i) & eth_bus_request_n_i)
                     : scsi_busy_n; // RQ5
      // The pin is read while still released, so the last sample before
      // the core wakes is the level that the pull resistor sets.
      if (hold) begin
         present_r <= eeprom_serial_clock_i; // RQ6
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign reg_rdata = rdata_r;
   assign io_target_abort = sleeping & acc; // RQ12
   assign eth_bus_request_n_o = ~requesting;
   assign eth_bus_request_oe = ~hold; // RQ5
   assign power_save = sleeping;
   assign soft_reset = sreset_r;
   assign bus_activity_n = busy_r; // RQ18
   assign bit_rate_tick = tick_r;
   assign eeprom_chip_select = cs_r & ~hold; // RQ2
   assign eeprom_present_flag = present_r;
   assign eeprom_serial_clock_o = sk_r;
   assign eeprom_serial_clock_oe = ~hold; // RQ2
   assign eeprom_data_in_line_o = di_r;
   assign eeprom_data_in_line_oe = ~hold;
   assign eeprom_data_out_line_o = do_r;
   assign eeprom_data_out_line_oe = ~hold & ~ee_access;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking

   sequence req_waiting;
      requesting && !grant;
   endsequence

   sequence sleep_during_req;
      req_waiting ##0 sleep_req;
   endsequence

   req_hold_a: assert property (disable iff (hold) // RQ1
      req_waiting |=> !eth_bus_request_n_o)
      else $error("bus request dropped before grant");
   reset_quiet_a: assert property (!rst_n |-> // RQ2
      !eth_bus_request_oe && !eeprom_serial_clock_oe &&
      !eeprom_data_in_line_oe && !eeprom_chip_select)
      else $error("output driven during reset");
   release_sync_a: assert property ($rose(rst_n) |-> hreset[*2]) // RQ4
      else $error("reset release not synchronised");
   nand_tree_a: assert property (hold ##1 hold |-> // RQ5
      bus_activity_n == !(nand_chain($past(nand_pins_i)) &&
                          $past(eth_bus_request_n_i)))
      else $error("nand tree result wrong");
   present_a: assert property (release_ev |-> // RQ6
      eeprom_present_flag == $past(eeprom_serial_clock_i))
      else $error("present flag not sampled");
   rx_default_a: assert property (disable iff (hold) // RQ7
      rx_cfg_r == ersc_pkg::RX_CFG_RST && !ee_access && !sleeping
      |=> eeprom_serial_clock_o == !$past(net_status[0]))
      else $error("receive indicator default wrong");
   link_default_a: assert property (disable iff (hold) // RQ9
      link_cfg_r == ersc_pkg::LINK_CFG_RST && !ee_access && !sleeping
      |=> eeprom_data_in_line_o == !$past(net_status[2]))
      else $error("link indicator default wrong");
   sleep_sreset_a: assert property (disable iff (hold) // RQ10
      enter_sleep |=> soft_reset && power_save)
      else $error("sleep entry without soft reset");
   abort_a: assert property (disable iff (hold) // RQ12
      sleeping && reg_req.rd |-> io_target_abort ##1 reg_rdata == 16'h0000)
      else $error("access while asleep not aborted");
   sleep_noreq_a: assert property (disable iff (hold) // RQ13
      sleeping |-> eth_bus_request_n_o)
      else $error("bus requested while asleep");
   drain_a: assert property (disable iff (hold) // RQ14
      sleep_during_req ##1 grant |=> power_save && eth_bus_request_n_o)
      else $error("drain did not end in sleep");
   sk_auto_a: assert property (disable iff (hold) // RQ21
      auto_read_busy && !sleeping |=>
      eeprom_serial_clock_o == $past(auto_sk))
      else $error("serial clock not from auto read");

endmodule : ersc_ctrl
`default_nettype wire

// [testbench/ersc_arb_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host arbiter stand-in. It grants only after the request has stood for a
// chosen number of cycles and keeps the grant until the request is dropped,
// so a slow answer can be set up on purpose.
module ersc_arb_model (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // Arbitration
   input  wire logic       req_n,
   input  wire logic [7:0] delay,
   output var  logic       grant_n
);
   logic [7:0] wait_r;

   always_ff @(posedge mclk) begin
      if (!rst_n || req_n) begin
         wait_r  <= 8'h00;
         grant_n <= 1'h1;
      end else if (wait_r >= delay) begin
         grant_n <= 1'h0;
      end else begin
         wait_r <= wait_r + 8'h01;
      end
   end
endmodule : ersc_arb_model
`default_nettype wire

// [testbench/ersc_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ersc_ctrl_tb;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic                         mclk, rst_n, want, sleep_n, busy_n, xtal;
   logic                         sk_pull, eeprom_data_out_line_drv, a_busy, a_sk, a_cs, a_di;
   logic                         abort, gnt_n, rq_o, rq_oe, psave, sres;
   logic                         act_n, tick, cs, present, xph, ab;
   logic                         sk_o, sk_oe, do_o, do_oe, di_o, di_oe;
   logic [3:0]                   net;
   logic [ersc_pkg::NAND_W-1:0]  nand_pins;
   logic [7:0]                   gdly;
   logic [15:0]                  rdata, d;
   ersc_pkg::ersc_reg_req_t      req;
   int                           mismatches, n_checks, sr_cnt, tk_cnt, rises;
   int                           n0, n1;
   logic [7:0]                   offs [4] = '{8'h04, 8'h08, 8'h0C, 8'h20};
   logic [15:0]                  dflt [4] = '{16'h0, 16'h2, 16'h4, 16'h0};
   // The wires settle to the pull or the far driver once the block lets go.
   wire logic                    rq_w = rq_oe ? rq_o : 1'h1;
   wire logic                    sk_w = sk_oe ? sk_o : sk_pull;
   wire logic                    do_w = do_oe ? do_o : eeprom_data_out_line_drv;

   // ------------------------------------------------------------
   // Design and partner
   // ------------------------------------------------------------
   ersc_ctrl i_dut (
      .mclk(mclk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
      .io_target_abort(abort), .want_bus(want), .eth_bus_grant_n(gnt_n),
      .eth_bus_request_n_i(rq_w), .eth_bus_request_n_o(rq_o),
      .eth_bus_request_oe(rq_oe), .sleep_n(sleep_n), .power_save(psave),
      .soft_reset(sres), .nand_pins_i(nand_pins), .scsi_busy_n(busy_n),
      .bus_activity_n(act_n), .net_status(net), .crystal_input(xtal),
      .bit_rate_tick(tick), .auto_read_busy(a_busy), .auto_sk(a_sk),
      .auto_cs(a_cs), .auto_di(a_di), .eeprom_chip_select(cs),
      .eeprom_present_flag(present), .eeprom_serial_clock_i(sk_w),
      .eeprom_serial_clock_o(sk_o), .eeprom_serial_clock_oe(sk_oe),
      .eeprom_data_out_line_i(do_w), .eeprom_data_out_line_o(do_o),
      .eeprom_data_out_line_oe(do_oe), .eeprom_data_in_line_o(di_o),
      .eeprom_data_in_line_oe(di_oe)
   );

   ersc_arb_model i_arb (
      .mclk(mclk), .rst_n(rst_n), .req_n(rq_w), .delay(gdly), .grant_n(gnt_n)
   );

   initial begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end

   // The crystal keeps running through sleep entry and exit.
   always @(posedge mclk) begin
      xph <= ~xph;
      if (xph) begin
         xtal <= ~xtal;
         if (!xtal) rises <= rises + 1;
      end
      if (sres) sr_cnt <= sr_cnt + 1;
      if (tick) tk_cnt <= tk_cnt + 1;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge mclk);
      req.wr    <= 1'h1;
      req.addr  <= a;
      req.wdata <= v;
      @(posedge mclk);
      req.wr <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge mclk);
      req.rd   <= 1'h1;
      req.addr <= a;
      #1 ab = abort;
      @(posedge mclk);
      req.rd <= 1'h0;
      #1 v = rdata;
   endtask : rd

   task automatic wait_req_off();
      int i;
      i = 0;
      while (rq_w !== 1'h1 && i < 100) begin
         cyc(1);
         i++;
      end
      if (rq_w !== 1'h1) begin
         mismatches++;
         results();
      end
   endtask : wait_req_off

   // Reset is held well past the minimum the block needs.
   task automatic do_reset(input logic pin);
      @(posedge mclk);
      rst_n     <= 1'h0;
      sk_pull   <= pin;
      nand_pins <= '1;
      cyc(32);
      chk(16'({rq_oe, sk_oe, do_oe, di_oe, cs}), 16'h0);
      d[0] = act_n;
      @(posedge mclk);
      nand_pins[0] <= 1'h0;
      cyc(3);
      chk(16'(act_n), {15'h0, ~d[0]});
      @(posedge mclk);
      rst_n <= 1'h1;
      cyc(6);
   endtask : do_reset

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      {rst_n, want, a_busy, a_sk, a_cs, a_di, xtal, xph} = '0;
      {sleep_n, busy_n, eeprom_data_out_line_drv, sk_pull} = 4'hF;
      {mismatches, n_checks, sr_cnt, tk_cnt, rises} = '0;
      req = '0;
      net = 4'h0;
      gdly = 8'h01;
      nand_pins = '1;
      do_reset(1'h1);
      chk(16'(present), 16'h1);
      @(posedge mclk);
      sk_pull <= 1'h0;
      cyc(3);
      chk(16'(present), 16'h1);
      for (int k = 0; k < 4; k++) begin
         rd(offs[k], d);
         chk(d, dflt[k]);
      end
      @(posedge mclk);
      net <= 4'hD;
      cyc(3);
      chk(16'({sk_oe, do_oe, di_oe, sk_o, do_o, di_o}), 16'h3A);
      wr(ersc_pkg::OFF_RX_CFG, 16'h0007);
      cyc(3);
      chk(16'(sk_o), 16'h1);
      $display("test reset and indicators done");
      wr(ersc_pkg::OFF_EE_CTRL, 16'h0006);
      cyc(2);
      chk(16'({cs, sk_oe, sk_o}), 16'h7);
      wr(ersc_pkg::OFF_EE_CTRL, 16'h0004);
      cyc(2);
      chk(16'(sk_o), 16'h0);
      wr(ersc_pkg::OFF_EE_CTRL, 16'h0000);
      @(posedge mclk);
      {a_busy, a_sk, a_cs} <= 3'h7;
      cyc(2);
      chk(16'({cs, sk_oe, sk_o}), 16'h7);
      @(posedge mclk);
      a_sk <= 1'h0;
      cyc(2);
      chk(16'(sk_o), 16'h0);
      @(posedge mclk);
      {a_busy, a_cs} <= 2'h0;
      wr(ersc_pkg::OFF_EE_CTRL, 16'h0006);
      $display("test serial memory done");
      @(posedge mclk);
      want <= 1'h1;
      @(posedge mclk);
      want <= 1'h0;
      cyc(1);
      chk(16'({rq_oe, rq_w}), 16'h2);
      wait_req_off();
      n0 = sr_cnt;
      @(posedge mclk);
      gdly <= 8'h14;
      want <= 1'h1;
      @(posedge mclk);
      want    <= 1'h0;
      sleep_n <= 1'h0;
      wr(ersc_pkg::OFF_SRESET, 16'h0000);
      cyc(8);
      chk(16'({rq_w, psave}), 16'h0);
      wait_req_off();
      cyc(2);
      chk(16'(psave), 16'h1);
      chk(16'(sr_cnt - n0), 16'h2);
      $display("test request and sleep entry done");
      rd(ersc_pkg::OFF_RX_CFG, d);
      chk(d, 16'h0);
      chk(16'(ab), 16'h1);
      wr(ersc_pkg::OFF_RX_CFG, 16'h0000);
      @(posedge mclk);
      want   <= 1'h1;
      busy_n <= 1'h0;
      cyc(6);
      chk(16'({cs, rq_w, act_n}), 16'h2);
      @(posedge mclk);
      want    <= 1'h0;
      sleep_n <= 1'h1;
      cyc(3);
      chk(16'(psave), 16'h0);
      // No network traffic is started after wake within this run.
      rd(ersc_pkg::OFF_RX_CFG, d);
      chk(d, 16'h0007);
      rd(ersc_pkg::OFF_EE_CTRL, d);
      chk(d & 16'h0006, 16'h0006);
      $display("test sleep and wake done");
      n0 = tk_cnt;
      n1 = rises;
      cyc(80);
      n0 = 2 * (tk_cnt - n0) - (rises - n1);
      chk(16'(n0 >= -2 && n0 <= 2), 16'h1);
      @(posedge mclk);
      busy_n <= 1'h1;
      cyc(3);
      chk(16'(act_n), 16'h1);
      do_reset(1'h0);
      chk(16'(present), 16'h0);
      rd(ersc_pkg::OFF_RX_CFG, d);
      chk(d, 16'h0000);
      $display("test second reset done");
      results();
   end

   initial begin
      #100000;
      mismatches++;
      results();
   end
endmodule : ersc_ctrl_tb
`default_nettype wire
